// File: logic/atsp_pkg.sv
// Purpose: Constants and types for the async timer status/prescaler block
// Assumes: One 8-bit register port in data-space addressing
// Notes: Register addresses and bit positions below
package atsp_pkg;
  localparam logic [7:0] ATSP_GEN_CTRL_ADDR = 8'h43;
  localparam logic [7:0] ATSP_IO_OFFSET = 8'h20;
  localparam logic [7:0] ATSP_STATUS_ADDR = 8'hb6;
  localparam logic [7:0] ATSP_FLAGS_ADDR = 8'h37;
  localparam logic [7:0] ATSP_MASK_ADDR = 8'h70;
  localparam logic [7:0] ATSP_COUNT_ADDR = 8'hb2;
  localparam logic [7:0] ATSP_CMPA_ADDR = 8'hb3;
  localparam logic [7:0] ATSP_CMPB_ADDR = 8'hb4;
  localparam logic [7:0] ATSP_CTLA_ADDR = 8'hb0;
  localparam logic [7:0] ATSP_CTLB_ADDR = 8'hb1;
  localparam logic [7:0] ATSP_RESET_VALUE = 8'h00;
  // Bit positions
  localparam int ATSP_B_EXTERNAL_CLOCK_SELECT = 6;
  localparam int ATSP_B_ASYNC = 5;
  localparam int ATSP_B_SYNC = 7;
  localparam int ATSP_B_PRASY = 1;
  localparam int ATSP_B_PRSH = 0;
  localparam int ATSP_B_CMPB = 2;
  localparam int ATSP_B_CMPA = 1;
  localparam int ATSP_B_OVF = 0;
  localparam int ATSP_BUSY_W = 5;
  // Busy vector order: count, cmpa, cmpb, ctla, ctlb (bits 4..0)
  localparam int ATSP_BY_CNT = 4;
  localparam int ATSP_BY_CMPA = 3;
  localparam int ATSP_BY_CMPB = 2;
  localparam int ATSP_BY_CTLA = 1;
  localparam int ATSP_BY_CTLB = 0;
  localparam logic [2:0] ATSP_SYNC_STAGES = 3'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } atsp_bus_t;

  typedef struct packed {
    logic sync_mode;
    logic async_psr;
    logic shared_psr;
    logic ext_clk;
    logic async_sel;
    logic [2:0] irq_en;
    logic [2:0] flags;
    logic [ATSP_BUSY_W-1:0] busy;
    logic [7:0] rdata;
  } atsp_state_t;
endpackage

// File: logic/atsp_xfer.sv
// Purpose: One busy-flag transfer tracker toward the timer domain
// Assumes: Done arrives as a synchronous pulse from the timer side
// Notes: Instantiated once per asynchronously updated register
`timescale 1ns/100ps
`default_nettype none
module atsp_xfer
  import atsp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic done_i,
  output logic busy_o
);
  logic busy;
  logic next_busy;

  // Start wins over done so a new write is never lost
  always_comb begin
    next_busy = busy;
    if (done_i) begin
      next_busy = 1'b0;
    end
    if (start_i) begin
      next_busy = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  assign busy_o = busy;
endmodule
`default_nettype wire

// File: logic/atsp_top.sv
// Purpose: Status, flags and prescaler control of the async 8-bit timer
// Assumes: Timer datapath outside reports count and compare A values, overflow and transfers
// Notes: Registers reached at data-space addresses; general control and flags also at short I/O addresses
`timescale 1ns/100ps
`default_nettype none
module atsp_top
  import atsp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic global_irq_en_i,
  input wire logic [7:0] timer_count_value_i,
  input wire logic [7:0] compare_a_value_i,
  input wire logic overflow_i,
  input wire logic pwm_mode_i,
  input wire logic bottom_reverse_i,
  input wire logic cmpa_vector_taken_i,
  input wire logic ovf_vector_taken_i,
  input wire logic [ATSP_BUSY_W-1:0] xfer_done_i,
  input wire logic async_psr_done_i,
  output logic compare_a_irq_o,
  output logic overflow_irq_o,
  output logic async_clock_select_o,
  output logic ext_clk_buffer_en_o,
  output logic crystal_osc_en_o,
  output logic async_psr_o,
  output logic shared_psr_o,
  output logic [ATSP_BUSY_W-1:0] busy_start_o
);
  atsp_state_t st;
  atsp_state_t next_st;
  atsp_bus_t bus;
  logic [ATSP_BUSY_W-1:0] busy_start;
  logic [ATSP_BUSY_W-1:0] busy_now;
  logic hit_gen;
  logic hit_stat;
  logic hit_flags;
  logic hit_mask;
  logic match_prev;
  logic match_now;
  logic psr_pend;
  logic next_psr_pend;
  logic ovf_event;

  assign bus = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                 wdata: reg_wdata_i};

  // Decode both address spaces for general control and flags; status and mask at data-space only
  always_comb begin
    hit_gen = (bus.addr == ATSP_GEN_CTRL_ADDR) ||
      (bus.addr == ATSP_GEN_CTRL_ADDR - ATSP_IO_OFFSET);
    hit_flags = (bus.addr == ATSP_FLAGS_ADDR) ||
      (bus.addr == ATSP_FLAGS_ADDR - ATSP_IO_OFFSET);
    hit_stat = (bus.addr == ATSP_STATUS_ADDR);
    hit_mask = (bus.addr == ATSP_MASK_ADDR);
  end

  // Async writes to timer registers start a transfer
  always_comb begin
    busy_start = '0;
    if (bus.wr && st.async_sel) begin
      busy_start[ATSP_BY_CNT] = (bus.addr == ATSP_COUNT_ADDR);
      busy_start[ATSP_BY_CMPA] = (bus.addr == ATSP_CMPA_ADDR);
      busy_start[ATSP_BY_CMPB] = (bus.addr == ATSP_CMPB_ADDR);
      busy_start[ATSP_BY_CTLA] = (bus.addr == ATSP_CTLA_ADDR);
      busy_start[ATSP_BY_CTLB] = (bus.addr == ATSP_CTLB_ADDR);
    end
  end

  // One tracker per async register
  for (genvar i = 0; i < ATSP_BUSY_W; i++) begin : g_busy
    atsp_xfer u_xfer (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(busy_start[i]),
      .done_i(xfer_done_i[i]),
      .busy_o(busy_now[i])
    );
  end

  // Match seen only on entry, so a held equal value sets once
  assign match_now = (timer_count_value_i == compare_a_value_i);

  // PWM reverses at bottom, so the wrap pulse is not its overflow
  assign ovf_event = pwm_mode_i ? bottom_reverse_i : overflow_i;

  // Register file and flag update
  always_comb begin
    next_st = st;
    next_psr_pend = psr_pend;
    next_st.busy = busy_now;
    // Flags: vector or write-one clears, then events set (set wins)
    if (cmpa_vector_taken_i) begin
      next_st.flags[ATSP_B_CMPA] = 1'b0;
    end
    if (ovf_vector_taken_i) begin
      next_st.flags[ATSP_B_OVF] = 1'b0;
    end
    if (bus.wr && hit_flags) begin
      next_st.flags = next_st.flags & ~bus.wdata[2:0];
    end
    if (match_now && !match_prev) begin
      next_st.flags[ATSP_B_CMPA] = 1'b1;
    end
    if (ovf_event) begin
      next_st.flags[ATSP_B_OVF] = 1'b1;
    end
    if (bus.wr && hit_mask) begin
      next_st.irq_en = bus.wdata[2:0];
    end
    // Busy bits are read-only; only the two clock bits are stored
    if (bus.wr && hit_stat) begin
      next_st.ext_clk = bus.wdata[ATSP_B_EXTERNAL_CLOCK_SELECT];
      next_st.async_sel = bus.wdata[ATSP_B_ASYNC];
    end
    // Prescaler resets self-clear unless held by sync mode; the async one is also held while pending
    if (!st.sync_mode) begin
      next_st.shared_psr = 1'b0;
      if (!psr_pend) begin
        next_st.async_psr = 1'b0;
      end
    end
    if (async_psr_done_i) begin
      next_psr_pend = 1'b0;
      if (!st.sync_mode) begin
        next_st.async_psr = 1'b0;
      end
    end
    if (bus.wr && hit_gen) begin
      next_st.sync_mode = bus.wdata[ATSP_B_SYNC];
      next_psr_pend = 1'b0; // A fresh write restarts pending tracking
      if (bus.wdata[ATSP_B_SYNC]) begin
        // Held values kept while sync mode stays on
        next_st.shared_psr = bus.wdata[ATSP_B_PRSH];
        next_st.async_psr = bus.wdata[ATSP_B_PRASY];
      end else begin
        // Release both so the timers restart together
        next_st.shared_psr = 1'b0;
        next_st.async_psr = 1'b0;
        if (bus.wdata[ATSP_B_PRASY] && st.async_sel) begin
          next_st.async_psr = 1'b1;
          next_psr_pend = 1'b1;
        end
      end
    end
    // Read data registered for the next cycle
    next_st.rdata = ATSP_RESET_VALUE;
    if (bus.rd) begin
      if (hit_gen) begin
        next_st.rdata = {st.sync_mode, 5'h00, st.async_psr, st.shared_psr};
      end else if (hit_stat) begin
        next_st.rdata = {1'b0, st.ext_clk, st.async_sel, st.busy};
      end else if (hit_flags) begin
        next_st.rdata = {5'h00, st.flags};
      end else if (hit_mask) begin
        next_st.rdata = {5'h00, st.irq_en};
      end
    end
  end

  // State register; contents across a clock switch are not protected
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      psr_pend <= 1'b0;
      match_prev <= 1'b1; // Equal reset values raise no false flag
    end else begin
      st <= next_st;
      psr_pend <= next_psr_pend;
      match_prev <= match_now;
    end
  end

  // Shared prescaler reset pulses on a plain write, not only when held
  assign shared_psr_o = st.shared_psr ||
    (bus.wr && hit_gen && bus.wdata[ATSP_B_PRSH]);
  assign async_psr_o = st.async_psr ||
    (bus.wr && hit_gen && bus.wdata[ATSP_B_PRASY]);

  // Interrupt requests gated by global and local enables
  assign compare_a_irq_o = global_irq_en_i && st.irq_en[ATSP_B_CMPA] &&
    st.flags[ATSP_B_CMPA];
  assign overflow_irq_o = global_irq_en_i && st.irq_en[ATSP_B_OVF] &&
    st.flags[ATSP_B_OVF];

  // Clock source selection; software orders these bits
  assign async_clock_select_o = st.async_sel;
  assign ext_clk_buffer_en_o = st.ext_clk && st.async_sel;
  assign crystal_osc_en_o = !st.ext_clk;
  assign busy_start_o = busy_start;
  assign reg_rdata_o = st.rdata;

  chk_cmpa_irq_gate: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    compare_a_irq_o |-> (global_irq_en_i && st.flags[ATSP_B_CMPA]))
    else $error("compare irq without flag");
  chk_ovf_irq_gate: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    overflow_irq_o |-> st.irq_en[ATSP_B_OVF])
    else $error("overflow irq while disabled");
  chk_cmpa_set: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (match_now && !match_prev) |=> st.flags[ATSP_B_CMPA])
    else $error("compare flag not set");
  chk_ovf_set: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (!pwm_mode_i && overflow_i) |=> st.flags[ATSP_B_OVF])
    else $error("overflow flag not set");
  chk_pwm_bottom: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (pwm_mode_i && bottom_reverse_i) |=> st.flags[ATSP_B_OVF])
    else $error("pwm bottom flag not set");
  chk_cmpa_vec_clr: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (cmpa_vector_taken_i && !(match_now && !match_prev))
      |=> !st.flags[ATSP_B_CMPA])
    else $error("compare flag not cleared");
  chk_sync_release: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.wr && hit_gen && !bus.wdata[ATSP_B_SYNC] && !st.async_sel)
      |=> (!st.shared_psr && !st.async_psr))
    else $error("prescaler resets not released");
  chk_sync_hold: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (st.sync_mode && st.shared_psr && !(bus.wr && hit_gen))
      |=> st.shared_psr)
    else $error("held prescaler reset dropped");
  chk_busy_set: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    busy_start[ATSP_BY_CNT] |=> ##1 st.busy[ATSP_BY_CNT])
    else $error("counter busy not shown");
  chk_clk_buffer: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    ext_clk_buffer_en_o |-> !crystal_osc_en_o)
    else $error("crystal runs with external clock");

  // Remaining gates of the two interrupt requests
  chk_cmpa_irq_mask: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    compare_a_irq_o |-> st.irq_en[ATSP_B_CMPA])
    else $error("compare irq while disabled");
  chk_ovf_irq_flag: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    overflow_irq_o |-> (global_irq_en_i && st.flags[ATSP_B_OVF]))
    else $error("overflow irq without flag");

  // Clears by write-one or vector; a set in the same cycle wins
  chk_cmpa_w1c: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.wr && hit_flags && bus.wdata[ATSP_B_CMPA] &&
      !(match_now && !match_prev)) |=> !st.flags[ATSP_B_CMPA])
    else $error("compare flag survived write one");
  chk_ovf_w1c: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.wr && hit_flags && bus.wdata[ATSP_B_OVF] && !ovf_event)
      |=> !st.flags[ATSP_B_OVF])
    else $error("overflow flag survived write one");
  chk_ovf_vec_clr: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (ovf_vector_taken_i && !ovf_event) |=> !st.flags[ATSP_B_OVF])
    else $error("overflow flag not cleared");
  chk_cmpa_hold: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (st.flags[ATSP_B_CMPA] && !cmpa_vector_taken_i &&
      !(bus.wr && hit_flags)) |=> st.flags[ATSP_B_CMPA])
    else $error("compare flag dropped by itself");
  chk_pwm_no_wrap: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (pwm_mode_i && overflow_i && !bottom_reverse_i &&
      !st.flags[ATSP_B_OVF]) |=> !st.flags[ATSP_B_OVF])
    else $error("pwm wrap set overflow flag");

  // Clock source follows the stored select bits
  chk_xtal_stop: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    st.ext_clk |-> !crystal_osc_en_o)
    else $error("crystal runs with external clock bit");
  chk_clk_source: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.wr && hit_stat) |=>
      (async_clock_select_o == $past(bus.wdata[ATSP_B_ASYNC])))
    else $error("clock source not taken from write");

  // Busy flags start only in async mode and follow their trackers
  chk_busy_sync: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    !st.async_sel |-> (busy_start == '0))
    else $error("busy start outside async mode");
  chk_cmpa_busy: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    busy_start[ATSP_BY_CMPA] |=> ##1 st.busy[ATSP_BY_CMPA])
    else $error("compare a busy not shown");
  chk_cmpb_clear: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (xfer_done_i[ATSP_BY_CMPB] && !busy_start[ATSP_BY_CMPB])
      |=> ##1 !st.busy[ATSP_BY_CMPB])
    else $error("compare b busy not cleared");
  chk_ctla_busy: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    busy_start[ATSP_BY_CTLA] |=> ##1 st.busy[ATSP_BY_CTLA])
    else $error("control a busy not shown");
  chk_ctlb_clear: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (xfer_done_i[ATSP_BY_CTLB] && !busy_start[ATSP_BY_CTLB])
      |=> ##1 !st.busy[ATSP_BY_CTLB])
    else $error("control b busy not cleared");
  chk_busy_ro: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.wr && hit_stat && (busy_now == '0)) |=> (st.busy == '0))
    else $error("busy bits took a write");

  // Prescaler reset bits: self-clear, hold in sync mode, pend in async
  chk_shared_clear: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (!st.sync_mode && !(bus.wr && hit_gen)) |=> !st.shared_psr)
    else $error("shared prescaler reset stuck");
  chk_async_clear: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (!st.sync_mode && !psr_pend && !(bus.wr && hit_gen))
      |=> !st.async_psr)
    else $error("async prescaler reset stuck");
  chk_async_pend: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (psr_pend && !async_psr_done_i && !(bus.wr && hit_gen))
      |=> st.async_psr)
    else $error("async prescaler reset dropped early");
  chk_sync_load: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.wr && hit_gen && bus.wdata[ATSP_B_SYNC]) |=>
      (st.async_psr == $past(bus.wdata[ATSP_B_PRASY])))
    else $error("held async reset not as written");

  // Short address alias and mask register
  chk_io_alias: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.rd && (bus.addr == ATSP_GEN_CTRL_ADDR - ATSP_IO_OFFSET)) |=>
      (reg_rdata_o[ATSP_B_SYNC] == $past(st.sync_mode)))
    else $error("short address read wrong");
  chk_mask_load: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (bus.wr && hit_mask) |=> (st.irq_en == $past(bus.wdata[2:0])))
    else $error("mask write not stored");
endmodule
`default_nettype wire

// File: verification/tb_atsp_top.sv
// Purpose: Self-checking bench for the async timer status block
// Assumes: Inputs change on the falling edge, one write per bus cycle
// Notes: Timer side events are single-cycle pulses from this bench, except the first transfer-done set, held three cycles
`timescale 1ns/100ps
`default_nettype none
module tb_atsp_top;
  import atsp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, gie = 1'b0, ovf = 1'b0, pwm = 1'b0, bot = 1'b0;
  logic vca = 1'b0, vov = 1'b0, pdone = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, cnt = 8'h00, cmpa = 8'h01;
  logic [4:0] xd = 5'h00;
  logic [7:0] rdat;
  logic [4:0] bstart, bs;
  logic ca_irq, ov_irq, asel, xbuf, xtal, apsr, spsr, sp;
  int err_count = 0;
  int n_compared = 0;
  localparam logic [7:0] ATSP_IO_FLAGS = ATSP_FLAGS_ADDR - ATSP_IO_OFFSET;
  always #25 sys_clk_i = ~sys_clk_i;
  atsp_top atsp_top_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_rdata_o(rdat), .global_irq_en_i(gie), .timer_count_value_i(cnt),
    .compare_a_value_i(cmpa), .overflow_i(ovf), .pwm_mode_i(pwm),
    .bottom_reverse_i(bot), .cmpa_vector_taken_i(vca),
    .ovf_vector_taken_i(vov), .xfer_done_i(xd), .async_psr_done_i(pdone),
    .compare_a_irq_o(ca_irq), .overflow_irq_o(ov_irq),
    .async_clock_select_o(asel), .ext_clk_buffer_en_o(xbuf),
    .crystal_osc_en_o(xtal), .async_psr_o(apsr), .shared_psr_o(spsr),
    .busy_start_o(bstart));
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Single write; busy start and shared reset sampled mid-cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    wr = 1'b1;
    addr = a;
    wdat = d;
    #10;
    bs = bstart;
    sp = spsr;
    @(negedge sys_clk_i);
    wr = 1'b0;
  endtask
  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    rd = 1'b1;
    addr = a;
    @(negedge sys_clk_i);
    rd = 1'b0;
    d = rdat;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e,
                            input string m);
    logic [7:0] v;
    rd_reg(a, v);
    chk(v, e, m);
  endtask
  // Pulse one timer-side input for one cycle
  task automatic pulse(ref logic s);
    @(negedge sys_clk_i);
    s = 1'b1;
    @(negedge sys_clk_i);
    s = 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic t_reset();
    expect_reg(ATSP_GEN_CTRL_ADDR, 8'h00, "gtc reset");
    expect_reg(ATSP_STATUS_ADDR, 8'h00, "status reset");
    expect_reg(ATSP_FLAGS_ADDR, 8'h00, "flags reset");
    expect_reg(ATSP_MASK_ADDR, 8'h00, "mask reset");
    expect_reg(8'h55, 8'h00, "unmapped");
    chk({7'h00, xtal}, 8'h01, "crystal at reset");
    $display("test reset done");
  endtask
  task automatic t_compare();
    wr_reg(ATSP_MASK_ADDR, 8'h07);
    expect_reg(ATSP_MASK_ADDR, 8'h07, "mask rw");
    cnt = 8'h01;
    @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    expect_reg(ATSP_FLAGS_ADDR, 8'h02, "cmpa flag set");
    chk({7'h00, ca_irq}, 8'h00, "irq without global");
    gie = 1'b1;
    #1 chk({7'h00, ca_irq}, 8'h01, "irq all set");
    cnt = 8'h02;
    wr_reg(ATSP_FLAGS_ADDR, 8'h02);
    expect_reg(ATSP_FLAGS_ADDR, 8'h00, "w1c cmpa");
    chk({7'h00, ca_irq}, 8'h00, "irq after clear");
    cnt = 8'h01;
    expect_reg(ATSP_FLAGS_ADDR, 8'h02, "cmpa set again");
    pulse(vca);
    expect_reg(ATSP_FLAGS_ADDR, 8'h00, "vector clears cmpa");
    $display("test compare done");
  endtask
  task automatic t_overflow();
    pulse(ovf);
    expect_reg(ATSP_FLAGS_ADDR, 8'h01, "ovf flag");
    chk({7'h00, ov_irq}, 8'h01, "ovf irq");
    wr_reg(ATSP_MASK_ADDR, 8'h02);
    chk({7'h00, ov_irq}, 8'h00, "ovf irq masked");
    pulse(vov);
    expect_reg(ATSP_FLAGS_ADDR, 8'h00, "vector clears ovf");
    // The wrap pulse is not the flag event in PWM operation
    pwm = 1'b1;
    pulse(ovf);
    expect_reg(ATSP_FLAGS_ADDR, 8'h00, "pwm ignores wrap");
    pulse(bot);
    expect_reg(ATSP_FLAGS_ADDR, 8'h01, "pwm bottom sets ovf");
    wr_reg(ATSP_IO_FLAGS, 8'h01);
    expect_reg(ATSP_FLAGS_ADDR, 8'h00, "w1c ovf via io");
    // Set beats a write-one that lands in the same cycle
    @(negedge sys_clk_i);
    wr = 1'b1;
    addr = ATSP_FLAGS_ADDR;
    wdat = 8'h01;
    bot = 1'b1;
    @(negedge sys_clk_i);
    wr = 1'b0;
    bot = 1'b0;
    expect_reg(ATSP_FLAGS_ADDR, 8'h01, "set wins over clear");
    // A vector clear must survive a write-one of another bit
    @(negedge sys_clk_i);
    wr = 1'b1;
    addr = ATSP_FLAGS_ADDR;
    wdat = 8'h02;
    vov = 1'b1;
    @(negedge sys_clk_i);
    wr = 1'b0;
    vov = 1'b0;
    expect_reg(ATSP_FLAGS_ADDR, 8'h00, "vector beside write");
    pwm = 1'b0;
    $display("test overflow done");
  endtask
  task automatic t_async();
    wr_reg(ATSP_CTLA_ADDR, 8'h11);
    chk({3'h0, bs}, 8'h00, "no busy when sync");
    wr_reg(ATSP_STATUS_ADDR, 8'h40);
    wr_reg(ATSP_STATUS_ADDR, 8'h7f);
    expect_reg(ATSP_STATUS_ADDR, 8'h60, "busy bits ignored");
    chk({5'h00, asel, xbuf, xtal}, 8'h06, "ext clock path");
    wr_reg(ATSP_COUNT_ADDR, 8'h33);
    chk({3'h0, bs}, 8'h10, "count busy start");
    expect_reg(ATSP_STATUS_ADDR, 8'h70, "count busy");
    // Each register is written once, never while its own flag is busy
    wr_reg(ATSP_CMPA_ADDR, 8'h01);
    wr_reg(ATSP_CMPB_ADDR, 8'h02);
    wr_reg(ATSP_CTLA_ADDR, 8'h03);
    wr_reg(ATSP_CTLB_ADDR, 8'h04);
    expect_reg(ATSP_STATUS_ADDR, 8'h7f, "all busy");
    xd = 5'h0a;
    pulse(pdone);
    xd = 5'h00;
    @(negedge sys_clk_i);
    expect_reg(ATSP_STATUS_ADDR, 8'h75, "partial clear");
    xd = 5'h15;
    @(negedge sys_clk_i);
    xd = 5'h00;
    repeat (3) @(negedge sys_clk_i);
    expect_reg(ATSP_STATUS_ADDR, 8'h60, "busy cleared");
    wr_reg(ATSP_GEN_CTRL_ADDR, 8'h02);
    expect_reg(ATSP_GEN_CTRL_ADDR, 8'h02, "async psr pending");
    chk({7'h00, apsr}, 8'h01, "async psr out");
    pulse(pdone);
    expect_reg(ATSP_GEN_CTRL_ADDR, 8'h00, "async psr done");
    wr_reg(ATSP_STATUS_ADDR, 8'h00);
    chk({5'h00, asel, xbuf, xtal}, 8'h01, "io clock path");
    $display("test async done");
  endtask
  task automatic t_prescaler();
    wr_reg(ATSP_GEN_CTRL_ADDR, 8'h01);
    chk({7'h00, sp}, 8'h01, "shared psr pulse");
    expect_reg(ATSP_GEN_CTRL_ADDR, 8'h00, "shared self clear");
    wr_reg(ATSP_GEN_CTRL_ADDR, 8'h02);
    expect_reg(ATSP_GEN_CTRL_ADDR, 8'h00, "async self clear");
    wr_reg(ATSP_GEN_CTRL_ADDR - ATSP_IO_OFFSET, 8'h83);
    expect_reg(ATSP_GEN_CTRL_ADDR, 8'h83, "sync holds");
    chk({6'h00, apsr, spsr}, 8'h03, "resets held");
    wr_reg(ATSP_GEN_CTRL_ADDR, 8'h00);
    expect_reg(ATSP_GEN_CTRL_ADDR - ATSP_IO_OFFSET, 8'h00,
               "sync off clears");
    chk({6'h00, apsr, spsr}, 8'h00, "resets released");
    $display("test prescaler done");
  endtask
  // Watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (20) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_compare();
    t_overflow();
    t_async();
    t_prescaler();
    conclude();
  end
endmodule
`default_nettype wire
